// ===== logic/uhp_port_status.sv
// Root hub per-port status and control for two downstream ports
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module uhp_port_status #(
    parameter logic [19:0] RESET_CYC = 20'(uhp_pkg::RESET_CYCLES),
    parameter logic [19:0] RESUME_CYC = 20'(uhp_pkg::RESUME_CYCLES),
    parameter logic [19:0] EOP_CYC = 20'(uhp_pkg::EOP_CYCLES),
    parameter logic [19:0] RESYNC_CYC = 20'(uhp_pkg::RESYNC_CYCLES)
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [1:0] connect_i,
    input wire logic [1:0] low_speed_i,
    input wire logic [1:0] overcurrent_i,
    input wire logic [1:0] babble_i,
    input wire logic txn_busy_i,
    input wire logic controller_resume_state_i,
    output logic [1:0] port_power_o,
    output logic [1:0] port_enable_o,
    output logic [1:0] port_reset_o,
    output logic [1:0] port_resume_o,
    output logic [1:0] port_eop_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [5:0] sync1;
    logic [5:0] sync2;
    wire logic [1:0] conn_s = sync2[1:0];
    wire logic [1:0] ls_s = sync2[3:2];
    wire logic [1:0] oc_s = sync2[5:4];

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
        end else begin
            sync1 <= {overcurrent_i, low_speed_i, connect_i};
            sync2 <= sync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration and hub-wide power commands

    logic [6:0] cfg;
    logic [1:0] announce;
    wire logic wr_cfg = wr_i && addr_i == uhp_pkg::ADDR_CFG;
    wire logic wr_glb = wr_i && addr_i == uhp_pkg::ADDR_GLOBAL;
    wire logic glb_clr = wr_glb && wdata_i[uhp_pkg::GLB_CLR_PWR];
    wire logic glb_set = wr_glb && wdata_i[uhp_pkg::GLB_SET_PWR];
    wire logic psm = cfg[uhp_pkg::CFG_PSM];
    wire logic [1:0] ppcm = cfg[uhp_pkg::CFG_PPCM +: 2];
    wire logic [1:0] dev_rem = cfg[uhp_pkg::CFG_DR +: 2];
    wire logic ppoc = cfg[uhp_pkg::CFG_PPOC];
    wire logic nps = cfg[uhp_pkg::CFG_NPS];

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg <= uhp_pkg::CFG_RESET;
            announce <= '1;
        end else begin
            announce <= announce & ~dev_rem;
            if (wr_cfg) begin
                cfg <= wdata_i[6:0];
            end
        end
    end

    // Armed by root hub reset, spent once a port is marked fixed

    ////////////////////////////////////////////////////////////////////////////////
    // Port register read image

    function automatic logic [31:0] port_word(input uhp_pkg::uhp_port_t st, input logic ccs,
                                              input logic oc, input logic pwr, input logic ls);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[uhp_pkg::B_CCS] = ccs;
        w[uhp_pkg::B_PES] = st.pes;
        w[uhp_pkg::B_PSS] = st.pss;
        w[uhp_pkg::B_POCI] = oc;
        w[uhp_pkg::B_PRS] = st.prs;
        w[uhp_pkg::B_PPS] = pwr;
        w[uhp_pkg::B_LSDA] = ls;
        w[uhp_pkg::B_CSC] = st.csc;
        w[uhp_pkg::B_PESC] = st.pesc;
        w[uhp_pkg::B_PSSC] = st.pssc;
        w[uhp_pkg::B_OCIC] = st.ocic;
        w[uhp_pkg::B_PRSC] = st.prsc;
        return w;
    endfunction

    logic [31:0] port_rd [2];

    ////////////////////////////////////////////////////////////////////////////////
    // Per-port logic

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_port
            uhp_pkg::uhp_port_t st;
            uhp_pkg::uhp_port_t next_st;
            uhp_pkg::uhp_pend_t pend;
            uhp_pkg::uhp_pend_t next_pend;
            uhp_pkg::uhp_seq_t seq;
            uhp_pkg::uhp_seq_t next_seq;
            logic [19:0] cnt;
            logic [19:0] next_cnt;

            wire logic [3:0] my_addr = (gi == 0) ? uhp_pkg::ADDR_PORT1 : uhp_pkg::ADDR_PORT2;
            wire logic wr_me = wr_i && addr_i == my_addr;
            // Writes held back while a transaction runs
            wire logic apply = pend.valid && !txn_busy_i;
            wire logic [31:0] wd = apply ? pend.data : 32'h0000_0000;
            // Power source: per-port or global commands
            wire logic port_ctl = psm && ppcm[gi];
            wire logic pw_set = port_ctl ? wd[uhp_pkg::B_PPS] : glb_set;
            wire logic pw_clr = port_ctl ? wd[uhp_pkg::B_LSDA] : glb_clr;
            wire logic pwr = nps || st.pps;
            // Over-current level only with per-port reporting
            wire logic oc = ppoc && oc_s[gi];
            // Connect is lost while power is off
            wire logic ccs = conn_s[gi] && pwr;
            wire logic ccs_rd = dev_rem[gi] || ccs;
            wire logic ls = ls_s[gi] && ccs;
            wire logic cnt_zero = cnt == 20'h00000;
            wire logic rst_done = seq == uhp_pkg::SEQ_RESET && cnt_zero;
            wire logic res_done = seq == uhp_pkg::SEQ_RESYNC && cnt_zero;
            wire logic hw_dis = oc || !ccs || !pwr || babble_i[gi];
            wire logic cmd_bad = !ccs && (wd[uhp_pkg::B_PES] || wd[uhp_pkg::B_PSS]
                                 || wd[uhp_pkg::B_PRS]);
            wire logic conn_ev = dev_rem[gi] ? announce[gi] : (ccs != st.ccs_q);
            // Sequence start requests
            wire logic start_rst = ccs && wd[uhp_pkg::B_PRS] && seq == uhp_pkg::SEQ_IDLE;
            wire logic start_res = wd[uhp_pkg::B_POCI] && st.pss && seq == uhp_pkg::SEQ_IDLE;

            always_comb begin
                next_pend = pend;
                if (apply) begin
                    next_pend.valid = 1'b0;
                end
                if (wr_me) begin
                    next_pend.valid = 1'b1;
                    next_pend.data = (pend.valid && !apply) ? (pend.data | wdata_i) : wdata_i;
                end
            end

            always_comb begin
                next_st = st;
                next_seq = seq;
                next_cnt = cnt_zero ? 20'h00000 : cnt - 20'h00001;
                next_st.ccs_q = ccs;
                next_st.oc_q = oc;
                // Software clears first, hardware sets afterwards override
                if (wd[uhp_pkg::B_CSC]) begin
                    next_st.csc = 1'b0;
                end
                if (wd[uhp_pkg::B_PESC]) begin
                    next_st.pesc = 1'b0;
                end
                if (wd[uhp_pkg::B_PSSC]) begin
                    next_st.pssc = 1'b0;
                end
                if (wd[uhp_pkg::B_OCIC]) begin
                    next_st.ocic = 1'b0;
                end
                if (wd[uhp_pkg::B_PRSC]) begin
                    next_st.prsc = 1'b0;
                end
                if (wd[uhp_pkg::B_CCS]) begin
                    next_st.pes = 1'b0;
                end
                if (ccs && wd[uhp_pkg::B_PES]) begin
                    next_st.pes = 1'b1;
                end
                if (ccs && wd[uhp_pkg::B_PSS]) begin
                    next_st.pss = 1'b1;
                end
                if (start_rst) begin
                    next_st.prs = 1'b1;
                    next_seq = uhp_pkg::SEQ_RESET;
                    next_cnt = RESET_CYC - 20'h00001;
                end
                // Resume only from suspend
                if (start_res) begin
                    next_seq = uhp_pkg::SEQ_RESUME;
                    next_cnt = RESUME_CYC - 20'h00001;
                end
                if (pw_set) begin
                    next_st.pps = 1'b1;
                end
                if (pw_clr) begin
                    next_st.pps = 1'b0;
                end
                case (seq)
                    uhp_pkg::SEQ_IDLE: begin
                    end
                    uhp_pkg::SEQ_RESET: begin
                        if (rst_done) begin
                            next_seq = uhp_pkg::SEQ_IDLE;
                            next_st.prs = 1'b0;
                            next_st.prsc = 1'b1;
                            next_st.pss = 1'b0;
                            next_st.pssc = 1'b0;
                            next_st.pes = ccs;
                        end
                    end
                    uhp_pkg::SEQ_RESUME: begin
                        if (cnt_zero) begin
                            next_seq = uhp_pkg::SEQ_EOP;
                            next_cnt = EOP_CYC - 20'h00001;
                        end
                    end
                    uhp_pkg::SEQ_EOP: begin
                        if (cnt_zero) begin
                            next_seq = uhp_pkg::SEQ_RESYNC;
                            next_cnt = RESYNC_CYC - 20'h00001;
                        end
                    end
                    uhp_pkg::SEQ_RESYNC: begin
                        if (res_done) begin
                            next_seq = uhp_pkg::SEQ_IDLE;
                            next_st.pssc = 1'b1;
                            next_st.pss = 1'b0;
                            next_st.pes = ccs;
                        end
                    end
                    default: begin
                        next_seq = uhp_pkg::SEQ_IDLE;
                    end
                endcase
                if (controller_resume_state_i) begin
                    next_st.pss = 1'b0;
                end
                if (oc) begin
                    next_st.pps = 1'b0;
                end
                // Hardware disable raises enable change
                if (st.pes && hw_dis) begin
                    next_st.pes = 1'b0;
                    next_st.pesc = 1'b1;
                end
                // Power off drops port state on the same edge
                if (!nps && !next_st.pps) begin
                    if (st.pes) begin
                        next_st.pesc = 1'b1;
                    end
                    next_st.pes = 1'b0;
                    next_st.pss = 1'b0;
                    next_st.prs = 1'b0;
                    next_seq = uhp_pkg::SEQ_IDLE;
                end
                // Refused commands while disconnected
                if (cmd_bad) begin
                    next_st.csc = 1'b1;
                end
                if (conn_ev) begin
                    next_st.csc = 1'b1;
                end
                if (oc != st.oc_q) begin
                    next_st.ocic = 1'b1;
                end
            end

            always_ff @(posedge mclk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    st <= '0;
                    pend <= '0;
                    seq <= uhp_pkg::SEQ_IDLE;
                    cnt <= 20'h00000;
                end else begin
                    st <= next_st;
                    pend <= next_pend;
                    seq <= next_seq;
                    cnt <= next_cnt;
                end
            end

            // Read image of the port
            assign port_rd[gi] = port_word(st, ccs_rd, oc, pwr, ls);
            assign port_power_o[gi] = pwr;
            assign port_enable_o[gi] = st.pes;
            assign port_reset_o[gi] = st.prs;
            assign port_resume_o[gi] = seq == uhp_pkg::SEQ_RESUME;
            assign port_eop_o[gi] = seq == uhp_pkg::SEQ_EOP;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe

    logic [31:0] next_rdata;
    wire logic [31:0] cfg_word = {25'h0000000, cfg};

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (rd_i) begin
            case (addr_i)
                uhp_pkg::ADDR_PORT1: next_rdata = port_rd[0];
                uhp_pkg::ADDR_PORT2: next_rdata = port_rd[1];
                uhp_pkg::ADDR_CFG: next_rdata = cfg_word;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= next_rdata;
        end
    end

endmodule

// ===== logic/uhp_pkg.sv
// Constants, types and register map of the root hub port status block
//
// How it works
// - Suspend bit set by write, cleared at resume end
// - Suspend write while disconnected sets connect change
// - Suspend cleared at reset end or controller resume
// - Bit 3 reads over-current pin, else zero
// - Writing bit 3 starts resume if suspended
// - Writing bit 4 starts port reset signalling
// - Reset change flag sets after 10 ms reset
// - Reset write while disconnected sets connect change
// - Power bit shows power, cleared by over-current
// - Switching mode and mask select command source
// - Power off clears connect, enable, suspend, reset
// - Bit 8 write sets power; no switching reads one
// - Bit 9 reads low-speed device attached
// - Writing bit 9 clears port power
// - Connect change on connect events, write one clears
// - Nonremovable port flags connect only after reset
// - Enable change on hardware enable clear or on power off
// - Suspend change after resume, EOP and resync
// - Over-current change sets on indicator change
// - Port writes wait until transaction completes
// - Bit 0 connect, nonremovable reads one, write clears enable
// - Enable cleared by hardware faults, set on completion
package uhp_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_PORT1 = 4'h0;
    localparam logic [3:0] ADDR_PORT2 = 4'h4;
    localparam logic [3:0] ADDR_CFG = 4'h8;
    localparam logic [3:0] ADDR_GLOBAL = 4'hC;

    localparam int B_CCS = 0;
    localparam int B_PES = 1;
    localparam int B_PSS = 2;
    localparam int B_POCI = 3;
    localparam int B_PRS = 4;
    localparam int B_PPS = 8;
    localparam int B_LSDA = 9;
    localparam int B_CSC = 16;
    localparam int B_PESC = 17;
    localparam int B_PSSC = 18;
    localparam int B_OCIC = 19;
    localparam int B_PRSC = 20;

    localparam int CFG_PSM = 0;
    localparam int CFG_PPCM = 1;
    localparam int CFG_DR = 3;
    localparam int CFG_PPOC = 5;
    localparam int CFG_NPS = 6;
    localparam int CFG_W = 7;
    localparam logic [6:0] CFG_RESET = 7'h00;

    localparam int GLB_CLR_PWR = 0;
    localparam int GLB_SET_PWR = 16;

    localparam int CLK_PERIOD_NS = 25;
    localparam int RESET_TIME_US = 10000;
    localparam int RESUME_TIME_US = 20000;
    localparam int EOP_TIME_NS = 1500;
    localparam int RESYNC_TIME_US = 3000;
    localparam int RESET_CYCLES = RESET_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int RESUME_CYCLES = RESUME_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int EOP_CYCLES = (EOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESYNC_CYCLES = RESYNC_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int CNT_W = 20;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_RESET,
        SEQ_RESUME,
        SEQ_EOP,
        SEQ_RESYNC
    } uhp_seq_t;

    typedef struct packed {
        logic ccs_q;
        logic oc_q;
        logic pes;
        logic pss;
        logic prs;
        logic pps;
        logic csc;
        logic pesc;
        logic pssc;
        logic ocic;
        logic prsc;
    } uhp_port_t;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } uhp_pend_t;
endpackage

// ===== sim/uhp_port_status_asserts.sv
// Port status checker bound to the root hub port block
`timescale 1ns/1ps
module uhp_port_status_asserts #(
    parameter logic [19:0] RESET_CYC = 20'h14
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [1:0] connect_i,
    input wire logic [1:0] low_speed_i,
    input wire logic [1:0] overcurrent_i,
    input wire logic [1:0] babble_i,
    input wire logic txn_busy_i,
    input wire logic controller_resume_state_i,
    input wire logic [1:0] port_power_o,
    input wire logic [1:0] port_enable_o,
    input wire logic [1:0] port_reset_o,
    input wire logic [1:0] port_resume_o,
    input wire logic [1:0] port_eop_o
);
    logic [19:0] rcnt;
    // Length of port 1 reset signalling
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rcnt <= 20'h0;
        end else begin
            rcnt <= port_reset_o[0] ? rcnt + 20'h1 : 20'h0;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    a_defer_write: assert property ($rose(port_reset_o[0]) |-> !$past(txn_busy_i))
        else $error("port reset began during a transaction");
    a_reset_len: assert property ($fell(port_reset_o[0]) && port_power_o[0] |->
        rcnt >= RESET_CYC - 20'h1 && rcnt <= RESET_CYC + 20'h1)
        else $error("port reset length wrong");
    a_power_gate: assert property ((~port_power_o & (port_enable_o | port_reset_o
        | port_resume_o | port_eop_o)) == 2'h0)
        else $error("unpowered port still active");
    a_oc_power: assert property ($rose(overcurrent_i[1]) |-> ##[1:4] !port_power_o[1])
        else $error("power kept on over-current");
    a_babble_drop: assert property (babble_i[0] && port_enable_o[0] |->
        ##[1:3] !port_enable_o[0])
        else $error("enable kept on babble");
    a_resume_eop: assert property ($fell(port_resume_o[0]) && port_power_o[0] |->
        port_eop_o[0])
        else $error("no end of packet after resume");
    a_resync_quiet: assert property ($fell(port_eop_o[0]) && port_power_o[0] |->
        !(port_resume_o[0] || port_reset_o[0]) [*8])
        else $error("port not quiet in resync");
    a_no_overlap: assert property (!(port_reset_o[0] && (port_resume_o[0] || port_eop_o[0])))
        else $error("reset and resume overlap");
    c_reset: cover property ($fell(port_reset_o[0]));
    c_eop: cover property ($rose(port_eop_o[0]));
    c_babble: cover property ($fell(port_enable_o[0]));
endmodule
bind uhp_port_status uhp_port_status_asserts #(.RESET_CYC(RESET_CYC)) u_chk (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .connect_i(connect_i),
    .low_speed_i(low_speed_i), .overcurrent_i(overcurrent_i), .babble_i(babble_i),
    .txn_busy_i(txn_busy_i), .controller_resume_state_i(controller_resume_state_i),
    .port_power_o(port_power_o), .port_enable_o(port_enable_o),
    .port_reset_o(port_reset_o), .port_resume_o(port_resume_o), .port_eop_o(port_eop_o)
);

// ===== sim/uhp_usb_dev.sv
// Behavioural devices on the two downstream ports
`timescale 1ns/1ps
module uhp_usb_dev (
    input wire logic [1:0] attach_i,
    input wire logic [1:0] ls_i,
    input wire logic [1:0] oc_i,
    input wire logic [1:0] babble_req_i,
    input wire logic [1:0] port_enable_i,
    output logic [1:0] connect_o,
    output logic [1:0] low_speed_o,
    output logic [1:0] overcurrent_o,
    output logic [1:0] babble_o
);
    assign connect_o = attach_i;
    // Speed pull-up only while a device sits on the port
    assign low_speed_o = attach_i & ls_i;
    assign overcurrent_o = oc_i;
    // Babble only on an enabled port
    assign babble_o = babble_req_i & port_enable_i;
endmodule

// ===== sim/tb_uhp_port_status.sv
// Self-checking bench for the root hub port status block
`timescale 1ns/1ps
module tb_uhp_port_status;
    localparam logic [3:0] P1 = uhp_pkg::ADDR_PORT1;
    localparam logic [3:0] P2 = uhp_pkg::ADDR_PORT2;
    localparam logic [3:0] CF = uhp_pkg::ADDR_CFG;
    localparam logic [3:0] GL = uhp_pkg::ADDR_GLOBAL;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic mclk_i = 1'h0;
    logic arst_n_i = 1'h0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'h0;
    logic rd_i = 1'h0;
    logic busy = 1'h0;
    logic cres = 1'h0;
    logic [1:0] att = 2'h0;
    logic [1:0] ls = 2'h0;
    logic [1:0] oc = 2'h0;
    logic [1:0] bab = 2'h0;
    logic [31:0] rdata_o;
    logic [1:0] con, lsp, ocp, bbp, pwr, en, prst, pres, peop;
    logic [31:0] cmds [3] = '{32'h2, 32'h4, 32'h10};
    int fails = 0;
    int n_compared = 0;
    uhp_port_status #(.RESET_CYC(20'h14), .RESUME_CYC(20'h1E), .EOP_CYC(20'h4),
        .RESYNC_CYC(20'hA)) u_dut (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .connect_i(con), .low_speed_i(lsp),
        .overcurrent_i(ocp), .babble_i(bbp), .txn_busy_i(busy),
        .controller_resume_state_i(cres), .port_power_o(pwr), .port_enable_o(en),
        .port_reset_o(prst), .port_resume_o(pres), .port_eop_o(peop));
    uhp_usb_dev u_dev (.attach_i(att), .ls_i(ls), .oc_i(oc), .babble_req_i(bab),
        .port_enable_i(en), .connect_o(con), .low_speed_o(lsp), .overcurrent_o(ocp),
        .babble_o(bbp));
    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wr_i <= 1'h1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'h0;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ck(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge mclk_i);
        rd_i <= 1'h1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'h0;
        #1;
        cmp($sformatf("reg %h", a), e, rdata_o & m);
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (3000) @(posedge mclk_i);
        fails++;
        end_sim;
    end
    initial begin
        repeat (10) @(posedge mclk_i);
        arst_n_i <= 1'h1;
        ck(P1, ALL, 32'h0);
        ck(4'h2, ALL, 32'h0);
        wr(GL, 32'h00010000);
        step(3);
        cmp("power", 32'h3, {30'h0, pwr});
        @(posedge mclk_i);
        att <= 2'h3;
        ls <= 2'h2;
        step(6);
        ck(P1, ALL, 32'h00010101);
        ck(P2, ALL, 32'h00010301);
        wr(P1, 32'h00010000);
        step(2);
        ck(P1, ALL, 32'h00000101);
        wr(P2, 32'h00010000);
        @(posedge mclk_i);
        att <= 2'h1;
        step(6);
        ck(P2, ALL, 32'h00010100);
        foreach (cmds[i]) begin
            wr(P2, 32'h00010000);
            wr(P2, cmds[i]);
            step(3);
            ck(P2, ALL, 32'h00010100);
        end
        @(posedge mclk_i);
        busy <= 1'h1;
        wr(P1, 32'h10);
        step(4);
        ck(P1, 32'h10, 32'h0);
        @(posedge mclk_i);
        busy <= 1'h0;
        step(2);
        cmp("reset", 32'h1, {30'h0, prst});
        step(30);
        ck(P1, ALL, 32'h00100103);
        wr(P1, 32'h8);
        step(3);
        cmp("resume", 32'h0, {30'h0, pres});
        wr(P1, 32'h4);
        step(3);
        ck(P1, 32'h4, 32'h4);
        wr(P1, 32'h8);
        step(3);
        cmp("resume", 32'h1, {30'h0, pres});
        ck(P1, 32'h4, 32'h4);
        step(27);
        cmp("eop", 32'h1, {30'h0, peop});
        step(22);
        ck(P1, ALL, 32'h00140103);
        wr(P1, 32'h4);
        wr(P1, 32'h10);
        step(30);
        ck(P1, ALL, 32'h00100103);
        wr(P1, 32'h4);
        @(posedge mclk_i);
        cres <= 1'h1;
        @(posedge mclk_i);
        cres <= 1'h0;
        step(2);
        ck(P1, 32'h4, 32'h0);
        wr(P1, 32'h1);
        step(3);
        ck(P1, 32'h00020003, 32'h1);
        wr(P1, 32'h2);
        step(3);
        cmp("enable", 32'h1, {30'h0, en});
        @(posedge mclk_i);
        bab <= 2'h1;
        step(4);
        cmp("enable", 32'h0, {30'h0, en});
        @(posedge mclk_i);
        bab <= 2'h0;
        ck(P1, 32'h00020002, 32'h00020000);
        wr(CF, 32'h20);
        @(posedge mclk_i);
        oc <= 2'h2;
        step(6);
        ck(P2, 32'h00080108, 32'h00080008);
        @(posedge mclk_i);
        oc <= 2'h0;
        step(6);
        ck(P2, 32'h8, 32'h0);
        wr(CF, 32'h3);
        wr(GL, 32'h00010000);
        wr(GL, 32'h1);
        wr(P2, 32'h100);
        step(3);
        cmp("power", 32'h1, {30'h0, pwr});
        wr(P1, 32'h200);
        step(3);
        cmp("power", 32'h0, {30'h0, pwr});
        ck(P1, 32'h17, 32'h0);
        wr(P1, 32'h100);
        step(3);
        cmp("power", 32'h1, {30'h0, pwr});
        wr(P1, 32'h00010000);
        wr(CF, 32'hB);
        ck(P1, 32'h00010000, 32'h00010000);
        wr(P1, 32'h00010000);
        @(posedge mclk_i);
        att <= 2'h0;
        step(6);
        ck(P1, 32'h00010001, 32'h1);
        wr(CF, 32'h40);
        ck(P2, 32'h100, 32'h100);
        ck(CF, ALL, 32'h40);
        end_sim;
    end
endmodule
